// ---- core/art_timer_defines.vh ----
// Register offsets, field positions and reset values of the PWM timer
// Included by the timer core; definitions only
`ifndef ART_TIMER_DEFINES_VH
`define ART_TIMER_DEFINES_VH
`define CSR_OFF 12'h000
`define CAR_OFF 12'h004
`define ARR_OFF 12'h008
`define PWM_CTRL_REG_OFF 12'h00C
`define DCR0_OFF 12'h010
`define ICCSR_OFF 12'h020
`define ICR0_OFF 12'h024
`define ICR1_OFF 12'h028
`define CTRL_OFF 12'h02C
`define CSR_CLOCK_SOURCE_SELECT 7
`define CSR_CC_HI 6
`define CSR_CC_LO 4
`define CSR_TCE 3
`define CSR_FORCE_RELOAD 2
`define CSR_OIE 1
`define CSR_OVF 0
`define RESET_BYTE 8'h00
`define PRESC_W 7
`endif

// ---- core/auto_reload_pwm_timer.v ----
// 8-bit auto-reload PWM timer with prescaler, four PWM channels and
// two input captures, reached as an APB slave.
// Assumes ext clock, capture inputs and halt are synchronous to mclk_in.
//
// Overview of operation
// - Counter increments once per prescaler tap rising edge while running.
// - Software reads or writes the counter at any time.
// - Overflow reloads counter from reload register; prescaler untouched.
// - Divide select n picks prescaler tap, dividing input by 2^n.
// - Clock source select picks CPU clock or external clock pin.
// - Run bit cleared freezes prescaler and counter; set counts.
// - Reset clears counter, prescaler, selects CPU clock.
// - Force reload or counter write also clears prescaler; prescaler hidden.
// - Hidden compare registers load from duty registers at overflow.
// - Output enable drives channel pin push-pull with PWM.
// - All channels share one period, 256 minus reload.
// - Overflow sets pin to polarity; compare match restores opposite.
// - PWM generation stops during Halt mode.
// - Overflow sets flag; interrupt request when overflow enable set.
// - External mode flags overflow after 256 minus reload events.
// - Selected capture edge latches counter and sets capture flag.
// - Per-channel edge select and capture interrupt enable.
// - Capture register locked until read; read clears flag.
// - Capture interrupt held while flag and enable set.
// - Enabled capture edge during Halt raises wake request.
// - Reading control/status register clears overflow flag.
// - Force reload bit is write-only and reads zero.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "art_timer_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module auto_reload_pwm_timer #(
  parameter CHANNELS = 4,
  parameter CAPTURES = 2
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire external_clock_in,
  input wire halt_in,
  input wire [CAPTURES-1:0] capture_in,
  output reg [CHANNELS-1:0] pwm_out,
  output wire [CHANNELS-1:0] pwm_oe_out,
  output wire overflow_irq_out,
  output wire capture_irq_out,
  output wire wakeup_out
);
  reg [7:0] csr_q;
  reg [7:0] count_q;
  reg [7:0] reload_q;
  reg [7:0] pwm_ctrl_reg_q;
  reg [`PRESC_W-1:0] presc_q;
  reg ext_prev_q;
  reg [8*CHANNELS-1:0] duty_q;
  reg [8*CHANNELS-1:0] cmp_q;
  reg [CAPTURES-1:0] cap_flag_q;
  reg [CAPTURES-1:0] cap_ie_q;
  reg [CAPTURES-1:0] cap_edge_q;
  reg [CAPTURES-1:0] cap_prev_q;
  reg [8*CAPTURES-1:0] cap_val_q;
  wire wr;
  wire rd;
  wire tick_src;
  wire tick;
  wire ovf_ev;
  wire car_wr;
  wire csr_rd;
  wire force_reload_wr;
  wire csr_wr;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // tap n rises when the low n prescaler bits carry out
  function tap_carry;
    input [`PRESC_W-1:0] p;
    input [2:0] n;
    begin
      case (n)
        3'h0: begin
          tap_carry = 1'b1;
        end
        3'h1: begin
          tap_carry = p[0];
        end
        3'h2: begin
          tap_carry = &p[1:0];
        end
        3'h3: begin
          tap_carry = &p[2:0];
        end
        3'h4: begin
          tap_carry = &p[3:0];
        end
        3'h5: begin
          tap_carry = &p[4:0];
        end
        3'h6: begin
          tap_carry = &p[5:0];
        end
        3'h7: begin
          tap_carry = &p[6:0];
        end
        default: begin
          tap_carry = 1'b0;
        end
      endcase
    end
  endfunction

  // Register index of a byte address; 4'hF when unmapped
  function [3:0] reg_index;
    input [11:0] a;
    begin
      case (a)
        `CSR_OFF: reg_index = 4'h0;
        `CAR_OFF: reg_index = 4'h1;
        `ARR_OFF: reg_index = 4'h2;
        `PWM_CTRL_REG_OFF: reg_index = 4'h3;
        `DCR0_OFF: reg_index = 4'h4;
        `DCR0_OFF + 12'h004: reg_index = 4'h5;
        `DCR0_OFF + 12'h008: reg_index = 4'h6;
        `DCR0_OFF + 12'h00C: reg_index = 4'h7;
        `ICCSR_OFF: reg_index = 4'h8;
        `ICR0_OFF: reg_index = 4'h9;
        `ICR1_OFF: reg_index = 4'hA;
        default: reg_index = 4'hF;
      endcase
    end
  endfunction

  assign wr = psel_in & penable_in & pwrite_in;
  assign rd = psel_in & penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign car_wr = wr & hit(paddr_in, `CAR_OFF);
  assign csr_rd = rd & hit(paddr_in, `CSR_OFF);
  assign csr_wr = wr & hit(paddr_in, `CSR_OFF);
  assign force_reload_wr = csr_wr & pwdata_in[`CSR_FORCE_RELOAD];

  // source select: external pin rising edge or every CPU cycle
  assign tick_src = csr_q[`CSR_CLOCK_SOURCE_SELECT] ? (external_clock_in & ~ext_prev_q)
                                    : 1'b1;
  // count on the selected tap's edge; tap 0 is the input
  assign tick = csr_q[`CSR_TCE] & tick_src &
    tap_carry(presc_q, csr_q[`CSR_CC_HI:`CSR_CC_LO]);
  // overflow when the counter wraps past 8'hFF
  assign ovf_ev = tick & (count_q == 8'hFF);

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_prev_q <= 1'b0;
      cap_prev_q <= {CAPTURES{1'b0}};
    end else begin
      ext_prev_q <= external_clock_in;
      cap_prev_q <= capture_in;
    end
  end

  // Prescaler and counter
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // reset clears counter and prescaler, CPU clock
      presc_q <= {`PRESC_W{1'b0}};
      count_q <= `RESET_BYTE;
    end else if (car_wr) begin
      count_q <= pwdata_in[7:0];
      presc_q <= {`PRESC_W{1'b0}};
    end else if (force_reload_wr) begin
      // force reload loads counter and clears prescaler
      count_q <= reload_q;
      presc_q <= {`PRESC_W{1'b0}};
    end else if (csr_q[`CSR_TCE] & tick_src) begin
      // run bit gates prescaler and counter counting; cleared means frozen
      presc_q <= presc_q + 7'h01;
      if (ovf_ev) begin
        count_q <= reload_q;
      end else if (tick) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // Control/status register
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      csr_q <= `RESET_BYTE;
    end else begin
      if (csr_wr) begin
        csr_q[7:1] <= {pwdata_in[7:3], 1'b0, pwdata_in[1]};
      end
      // set wins over the read clear
      if (ovf_ev) begin
        csr_q[`CSR_OVF] <= 1'b1;
      end else if (csr_rd) begin
        csr_q[`CSR_OVF] <= 1'b0;
      end
    end
  end

  // Reload value
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_q <= `RESET_BYTE;
    end else if (wr & hit(paddr_in, `ARR_OFF)) begin
      reload_q <= pwdata_in[7:0];
    end
  end

  // PWM enables and polarities
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_ctrl_reg_q <= `RESET_BYTE;
    end else if (wr & hit(paddr_in, `PWM_CTRL_REG_OFF)) begin
      pwm_ctrl_reg_q <= pwdata_in[7:0];
    end
  end

  // capture edge select and interrupt enables
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_ie_q <= {CAPTURES{1'b0}};
      cap_edge_q <= {CAPTURES{1'b0}};
    end else if (wr & hit(paddr_in, `ICCSR_OFF)) begin
      cap_edge_q <= pwdata_in[2 +: CAPTURES];
      cap_ie_q <= pwdata_in[4 +: CAPTURES];
    end
  end

  // PWM channels
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      // Software side of the double buffer
      always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          duty_q[8*g +: 8] <= 8'h00;
        end else if (wr &
          ({28'h000_0000, reg_index(paddr_in)} == 4 + g)) begin
          duty_q[8*g +: 8] <= pwdata_in[7:0];
        end
      end
      always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cmp_q[8*g +: 8] <= 8'h00;
          pwm_out[g] <= 1'b0;
        end else if (!halt_in) begin
          if (ovf_ev) begin
            cmp_q[8*g +: 8] <= duty_q[8*g +: 8];
            pwm_out[g] <= pwm_ctrl_reg_q[g];
          end else if (tick && (count_q + 8'h01) == cmp_q[8*g +: 8]) begin
            pwm_out[g] <= ~pwm_ctrl_reg_q[g];
          end
        end
      end
      assign pwm_oe_out[g] = pwm_ctrl_reg_q[4 + g];
    end
  endgenerate

  // Input capture
  generate
    for (g = 0; g < CAPTURES; g = g + 1) begin : cap
      wire edge_hit;
      wire val_rd;
      // edge select: 1 rising, 0 falling
      assign edge_hit = cap_edge_q[g] ? (capture_in[g] & ~cap_prev_q[g])
                                      : (~capture_in[g] & cap_prev_q[g]);
      assign val_rd = rd &
        ({28'h000_0000, reg_index(paddr_in)} == 9 + g);
      always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cap_flag_q[g] <= 1'b0;
          cap_val_q[8*g +: 8] <= 8'h00;
        end else if (edge_hit & ~cap_flag_q[g]) begin
          cap_val_q[8*g +: 8] <= count_q;
          cap_flag_q[g] <= 1'b1;
        end else if (val_rd) begin
          // read releases lock and clears flag
          cap_flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign overflow_irq_out = csr_q[`CSR_OVF] & csr_q[`CSR_OIE];
  assign capture_irq_out = |(cap_flag_q & cap_ie_q);
  // enabled capture edge wakes from halt
  assign wakeup_out = halt_in & capture_irq_out;

  // Read data muxed from registers; zero wait states
  always @* begin
    prdata_out = 32'h0000_0000;
    case (reg_index(paddr_in))
      4'h0: prdata_out[7:0] = csr_q;
      4'h1: prdata_out[7:0] = count_q;
      4'h2: prdata_out[7:0] = reload_q;
      4'h3: prdata_out[7:0] = pwm_ctrl_reg_q;
      4'h4: prdata_out[7:0] = duty_q[7:0];
      4'h5: prdata_out[7:0] = duty_q[15:8];
      4'h6: prdata_out[7:0] = duty_q[23:16];
      4'h7: prdata_out[7:0] = duty_q[31:24];
      4'h8: prdata_out[7:0] = {2'h0, cap_ie_q, cap_edge_q, cap_flag_q};
      4'h9: prdata_out[7:0] = cap_val_q[7:0];
      4'hA: prdata_out[7:0] = cap_val_q[15:8];
      default: prdata_out = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// ---- test/art_props.sv ----
// Checker: port-level properties of the PWM timer
// Assumes it is bound onto auto_reload_pwm_timer
`timescale 1ns/1ns
`default_nettype none
module art_props #(
  parameter CHANNELS = 4,
  parameter CAPTURES = 2
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic halt_in,
  input wire logic [CHANNELS-1:0] pwm_out,
  input wire logic [CHANNELS-1:0] pwm_oe_out,
  input wire logic overflow_irq_out,
  input wire logic capture_irq_out
);
  wire acc = psel_in & penable_in;
  wire oe_wr = acc & pwrite_in & (paddr_in == 12'h00C);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  AST_READY: assert property (pready_out)
    else $error("pready low");
  AST_FORCE_RELOAD_ZERO: assert property (
    acc && !pwrite_in && paddr_in == 12'h000 |-> !prdata_out[2])
    else $error("force reload bit read high");
  AST_UPPER: assert property (
    acc && !pwrite_in |-> prdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_OE: assert property (
    oe_wr |=> pwm_oe_out == $past(pwdata_in[7:4]))
    else $error("output enables not written");
  AST_OE_HOLD: assert property (!oe_wr |=> $stable(pwm_oe_out))
    else $error("output enables moved");
  AST_HALT: assert property (halt_in [*3] |-> $stable(pwm_out))
    else $error("pwm moved in halt");
  AST_CIRQ_FALL: assert property (
    $fell(capture_irq_out) |-> $past(acc && paddr_in[11:4] == 8'h02))
    else $error("capture irq dropped without access");
  AST_OIRQ_FALL: assert property (
    $fell(overflow_irq_out) |-> $past(acc && paddr_in == 12'h000))
    else $error("overflow irq dropped without access");
endmodule
`default_nettype wire

// ---- test/art_pins.sv ----
// Partner: external clock and capture pins facing the timer
// Assumes tasks are called from the mclk domain, one at a time
`timescale 1ns/1ns
`default_nettype none
module art_pins (
  input wire logic mclk_in,
  output logic external_clock_in,
  output logic [1:0] capture_in
);
  initial begin
    external_clock_in = 1'b0;
    capture_in = 2'b00;
  end
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge mclk_in) external_clock_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      external_clock_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic set_cap(input int ch, input logic v);
    @(posedge mclk_in) capture_in[ch] <= v;
    repeat (3) @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// ---- test/auto_reload_pwm_timer_test.sv ----
// Testbench: APB register sequences against the PWM timer
// Assumes the pin partner and checker files are compiled first
`timescale 1ns/1ns
`default_nettype none
module auto_reload_pwm_timer_test;
  logic mclk_in, rst_n_in, psel_in, penable_in, pwrite_in, halt_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, external_clock_in, overflow_irq_out;
  wire capture_irq_out, wakeup_out;
  wire [1:0] capture_in;
  wire [3:0] pwm_out, pwm_oe_out;
  int mismatches = 0;
  int samples_checked = 0;
  auto_reload_pwm_timer dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .external_clock_in(external_clock_in), .halt_in(halt_in),
    .capture_in(capture_in), .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out),
    .overflow_irq_out(overflow_irq_out), .wakeup_out(wakeup_out),
    .capture_irq_out(capture_irq_out));
  art_pins pins (.mclk_in(mclk_in), .external_clock_in(external_clock_in),
    .capture_in(capture_in));
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      r = prdata_out;
    end while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h00_0000, d}, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk($sformatf("reg %h", a), r, e);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, halt_in} = 5'h00;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 16; i += 4) rd(12'(i), 32'h0000_0000);
    rd(12'h03C, 32'h0000_0000);
    wr(12'h008, 8'hF0);
    wr(12'h000, 8'h04);
    rd(12'h004, 32'h0000_00F0);
    rd(12'h000, 32'h0000_0000);
    rd(12'h004, 32'h0000_00F0);
    $display("test init done");
    for (int n = 0; n < 8; n++) begin
      wr(12'h000, {1'b1, n[2:0], 4'h8});
      wr(12'h004, 8'h10);
      pins.ext_pulses((1 << n) - 1);
      rd(12'h004, 32'h0000_0010);
      pins.ext_pulses(1);
      rd(12'h004, 32'h0000_0011);
    end
    $display("test divide done");
    wr(12'h008, 8'hF0);
    wr(12'h000, 8'h8E);
    pins.ext_pulses(15);
    chk("oirq", 32'(overflow_irq_out), 32'h0000_0000);
    pins.ext_pulses(1);
    chk("oirq", 32'(overflow_irq_out), 32'h0000_0001);
    rd(12'h004, 32'h0000_00F0);
    rd(12'h000, 32'h0000_008B);
    rd(12'h000, 32'h0000_008A);
    $display("test overflow done");
    wr(12'h00C, 8'hF5);
    for (int c = 0; c < 4; c++) wr(12'(16 + 4 * c), 8'hFE);
    wr(12'h008, 8'hFC);
    wr(12'h000, 8'h8C);
    pins.ext_pulses(4);
    chk("pwm", 32'(pwm_out), 32'h0000_0005);
    pins.ext_pulses(2);
    chk("pwm", 32'(pwm_out), 32'h0000_000A);
    pins.ext_pulses(2);
    chk("pwm", 32'(pwm_out), 32'h0000_0005);
    chk("oe", 32'(pwm_oe_out), 32'h0000_000F);
    $display("test pwm done");
    wr(12'h000, 8'h00);
    wr(12'h004, 8'h5A);
    wr(12'h020, 8'h3C);
    halt_in <= 1'b1;
    pins.set_cap(0, 1'b1);
    chk("wake", 32'(wakeup_out), 32'h0000_0001);
    chk("cirq", 32'(capture_irq_out), 32'h0000_0001);
    halt_in <= 1'b0;
    rd(12'h020, 32'h0000_003D);
    wr(12'h004, 8'h66);
    pins.set_cap(0, 1'b0);
    pins.set_cap(0, 1'b1);
    rd(12'h024, 32'h0000_005A);
    @(posedge mclk_in);
    chk("cirq", 32'(capture_irq_out), 32'h0000_0000);
    rd(12'h020, 32'h0000_003C);
    wr(12'h020, 8'h34);
    wr(12'h004, 8'h11);
    pins.set_cap(1, 1'b1);
    wr(12'h004, 8'h22);
    pins.set_cap(1, 1'b0);
    rd(12'h028, 32'h0000_0022);
    $display("test capture done");
    end_of_test();
  end
endmodule
bind auto_reload_pwm_timer art_props #(.CHANNELS(CHANNELS),
  .CAPTURES(CAPTURES)) props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .halt_in(halt_in), .pwm_out(pwm_out),
  .pwm_oe_out(pwm_oe_out), .overflow_irq_out(overflow_irq_out),
  .capture_irq_out(capture_irq_out));
`default_nettype wire
